// *** src/adr_pkg.sv ***
// adr_pkg: register map, field positions, reset values and timing figures
// for the conversion-done / output-latch / read-checksum block.
// assumes a 32-bit AXI4-Lite register bus and one 125 MHz system clock.
package adr_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PHASE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CONV  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STAT  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_CHK   = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_DATA0 = 8'h20;

	// control register fields
	localparam int CTRL_SRST_LSB  = 0;
	localparam int CTRL_SHDN_LSB  = 4;
	localparam int CTRL_HIZ       = 8;
	localparam int CTRL_JOINT     = 9;
	localparam int CTRL_CRC_EN    = 10;
	localparam int CTRL_CRC32     = 11;
	localparam int CTRL_LOOP      = 12;
	localparam int CTRL_START_LSB = 13;
	localparam int CTRL_ALERT_EN  = 15;
	localparam logic [31:0] CTRL_RST = 32'h0000_1300;

	// converter settings fields; any change restarts the converters
	localparam int CONV_RATIO_LSB = 0;
	localparam int CONV_PRE_LSB   = 3;
	localparam int CONV_EXT_CLK   = 5;
	localparam int CONV_EXT_REF   = 6;
	localparam int CONV_BITS    = 7;
	localparam logic [31:0] CONV_RST  = 32'h0000_0003;
	localparam logic [31:0] PHASE_RST = 32'h0000_0000;

	// status fields
	localparam int STAT_ALERT = 4;

	// read checksum
	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam logic [15:0] CRC_INIT = 16'h0000;

	// timing: converter period in system clocks = DIVCLK_MIN * BASE_RATIO << (pre + ratio)
	localparam int DIVCLK_MIN    = 2;
	localparam int BASE_RATIO    = 32;
	localparam int SINC_ORDER    = 3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {SP_IDLE, SP_DATA, SP_CRC} adr_spi_e;

endpackage : adr_pkg

// *** src/adr_core.sv ***
// adr_core: converter restart, conversion-done pin, two-stage output latches
// and read checksum on the serial output, with an AXI4-Lite register slave.
// assumes SCK_IN and CS_N_IN are already synchronous to MCLK_IN and that SCK
// runs well below MCLK/2; the config checksum engine lives outside.
// Function
// (R1) restart active converters on phase write or converter setting change
// (R2) converters resume by themselves; channel output data cleared on restart
// (R3) rewriting the same phase value also restarts the active converters
// (R4) each conversion end gives a low pulse half a divided clock wide
// (R5) output data updated right after the pulse falling edge
// (R6) first pulse after reset waits filter settling plus channel delay
// (R7) later pulses are periodic at the output rate period
// (R8) idle pin floats when tristate select is 0, driven high when 1
// (R9) host sets tristate select to 1 when it is the only device
// (R10) chip select never affects the conversion-done pin
// (R11) converter reset pin low keeps the conversion-done pin inactive
// (R12) config checksum alert holds the conversion-done pin low
// (R13) first latch stage captures results, all active together when joint
// (R14) second latch freezes a channel when its serial read begins
// (R15) host clocks out a whole channel before moving on
// (R16) host waits the update delay after a pulse before reading
// (R17) ready flags go 0 on new data; polling them needs no delay
// (R18) checksum appended after each continuous read sequence when enabled
// (R19) checksum is CRC-16 with polynomial 0x8005
// (R20) checksum sent in 16 or 32 bit field, value unchanged
// (R21) receiver expects zero CRC over sequence plus checksum
// (R22) checksum inserted only at end of the selected set
// (R23) after last address of the set the read loops to its first
// (R24) enabled checksum mismatch drives the pin low until cleared
// (R25) checksum restarts from its initial value each new sequence
`timescale 1ns/1ps

module adr_core #(
	parameter int NCH   = 4,
	parameter int DW    = 24,
	parameter int CNT_W = 20
) (
	// clock and reset
	input  wire logic                        MCLK_IN,
	input  wire logic                        RST_N_IN,
	// axi4-lite write
	input  wire logic                        S_AXI_AWVALID_IN,
	output wire logic                        S_AXI_AWREADY_OUT,
	input  wire logic [adr_pkg::ADDR_W-1:0]  S_AXI_AWADDR_IN,
	input  wire logic                        S_AXI_WVALID_IN,
	output wire logic                        S_AXI_WREADY_OUT,
	input  wire logic [adr_pkg::DATA_W-1:0]  S_AXI_WDATA_IN,
	input  wire logic [3:0]                  S_AXI_WSTRB_IN,
	output wire logic                        S_AXI_BVALID_OUT,
	input  wire logic                        S_AXI_BREADY_IN,
	output wire logic [1:0]                  S_AXI_BRESP_OUT,
	// axi4-lite read
	input  wire logic                        S_AXI_ARVALID_IN,
	output wire logic                        S_AXI_ARREADY_OUT,
	input  wire logic [adr_pkg::ADDR_W-1:0]  S_AXI_ARADDR_IN,
	output wire logic                        S_AXI_RVALID_OUT,
	input  wire logic                        S_AXI_RREADY_IN,
	output wire logic [adr_pkg::DATA_W-1:0]  S_AXI_RDATA_OUT,
	output wire logic [1:0]                  S_AXI_RRESP_OUT,
	// converter side
	input  wire logic                        ADC_RESET_N_IN,
	input  wire logic [NCH*DW-1:0]           CH_RESULT_IN,
	input  wire logic                        CFG_CRC_MISMATCH_IN,
	// serial read port
	input  wire logic                        SCK_IN,
	input  wire logic                        CS_N_IN,
	output wire logic                        SDO_OUT,
	output wire logic                        SDO_OE_OUT,
	// conversion-done pin
	output wire logic                        CONV_DONE_N_OUT,
	output wire logic                        CONV_DONE_OE_OUT
);
	import adr_pkg::*;

	localparam int CH_W = $clog2(NCH);

	logic [31:0]          ctrl_ff;
	logic [31:0]          phase_ff;
	logic [31:0]          conv_ff;
	logic                 aw_ff;
	logic                 w_ff;
	logic [ADDR_W-1:0]    awaddr_ff;
	logic [31:0]          wdata_ff;
	logic [3:0]           wstrb_ff;
	logic                 bvalid_ff;
	logic [1:0]           bresp_ff;
	logic                 rvalid_ff;
	logic [31:0]          rdata_ff;
	logic [1:0]           rresp_ff;
	logic                 restart_ff;
	logic [DW-1:0]        data_ff [NCH];
	logic [NCH-1:0]       ready_n_ff;
	logic [15:0]          chk_ff;
	logic [CNT_W-1:0]     cnt_ff [NCH];
	logic [CNT_W-1:0]     pulse_ff;
	logic                 done_n_ff;
	logic                 done_oe_ff;
	logic                 sck_q_ff;
	adr_spi_e             state_ff;
	logic [CH_W-1:0]      ch_ff;
	logic [4:0]           bit_ff;
	logic [31:0]          sh_ff;
	logic [15:0]          crc_ff;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i+:8] = nw[8*i+:8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
	endfunction : crc_step

	// register write: address and data may arrive in either order
	wire         wr_go   = aw_ff && w_ff && !bvalid_ff;
	wire [31:0]  wr_val  = merge((awaddr_ff == OFS_CTRL) ? ctrl_ff :
			(awaddr_ff == OFS_PHASE) ? phase_ff : conv_ff, wdata_ff, wstrb_ff);
	wire         wr_hit  = (awaddr_ff == OFS_CTRL) || (awaddr_ff == OFS_PHASE)
			|| (awaddr_ff == OFS_CONV);

	assign S_AXI_AWREADY_OUT = !aw_ff && !bvalid_ff;
	assign S_AXI_WREADY_OUT  = !w_ff && !bvalid_ff;
	assign S_AXI_BVALID_OUT  = bvalid_ff;
	assign S_AXI_BRESP_OUT   = bresp_ff;
	assign S_AXI_ARREADY_OUT = !rvalid_ff;
	assign S_AXI_RVALID_OUT  = rvalid_ff;
	assign S_AXI_RDATA_OUT   = rdata_ff;
	assign S_AXI_RRESP_OUT   = rresp_ff;

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			aw_ff     <= 1'b0;
			w_ff      <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff  <= '0;
			wstrb_ff  <= '0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
				aw_ff     <= 1'b1;
				awaddr_ff <= S_AXI_AWADDR_IN;
			end else if (wr_go) begin
				aw_ff <= 1'b0;
			end
			if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
				w_ff     <= 1'b1;
				wdata_ff <= S_AXI_WDATA_IN;
				wstrb_ff <= S_AXI_WSTRB_IN;
			end else if (wr_go) begin
				w_ff <= 1'b0;
			end
			if (wr_go) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY_IN) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ctrl_ff  <= CTRL_RST;
			phase_ff <= PHASE_RST;
			conv_ff  <= CONV_RST;
		end else if (wr_go) begin
			if (awaddr_ff == OFS_CTRL) begin
				ctrl_ff <= wr_val;
			end
			if (awaddr_ff == OFS_PHASE) begin
				phase_ff <= wr_val;
			end
			if (awaddr_ff == OFS_CONV) begin
				conv_ff <= wr_val;
			end
		end
	end

	// any phase write, even of the same value, counts; reset value forces a first load
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			restart_ff <= 1'b1;
		end else begin
			restart_ff <= wr_go && ((awaddr_ff == OFS_PHASE) // R1 R3
					|| (awaddr_ff == OFS_CONV
					&& wr_val[CONV_BITS-1:0] != conv_ff[CONV_BITS-1:0])); // R1
		end
	end

	// register read
	logic [31:0] rd_val;
	logic        rd_hit;
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (S_AXI_ARADDR_IN)
			OFS_CTRL:  rd_val = ctrl_ff;
			OFS_PHASE: rd_val = phase_ff;
			OFS_CONV:  rd_val = conv_ff;
			OFS_STAT:  rd_val = {27'h0, ctrl_ff[CTRL_ALERT_EN] && CFG_CRC_MISMATCH_IN,
					ready_n_ff}; // R17
			OFS_CHK:   rd_val = {16'h0000, chk_ff};
			default:   rd_hit = 1'b0;
		endcase
		for (int i = 0; i < NCH; i++) begin
			if (S_AXI_ARADDR_IN == OFS_DATA0 + ADDR_W'(4 * i)) begin
				rd_val = {{(32-DW){1'b0}}, data_ff[i]};
				rd_hit = 1'b1;
			end
		end
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= RESP_OKAY;
		end else if (S_AXI_ARVALID_IN && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_val;
			rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RREADY_IN) begin
			rvalid_ff <= 1'b0;
		end
	end

	// converter timing, counted in system clocks
	wire [2:0]       ratio    = conv_ff[CONV_RATIO_LSB+:3];
	wire [1:0]       pre      = conv_ff[CONV_PRE_LSB+:2];
	wire [CNT_W-1:0] dm_div   = CNT_W'(DIVCLK_MIN) << pre;
	// shift amount is 4 bits wide: ratio plus prescaler reaches ten
	wire [CNT_W-1:0] period   = CNT_W'(DIVCLK_MIN * BASE_RATIO) << (4'(ratio) + 4'(pre));
	wire [CNT_W-1:0] half_dm  = dm_div >> 1;
	wire             joint    = ctrl_ff[CTRL_JOINT];
	wire             alert    = ctrl_ff[CTRL_ALERT_EN] && CFG_CRC_MISMATCH_IN;

	logic [NCH-1:0] active;
	logic [NCH-1:0] evt;
	logic [NCH-1:0] latch;
	logic [NCH-1:0] rd_start;
	logic           lead_evt;
	logic           found;

	always_comb begin
		lead_evt = 1'b0;
		found    = 1'b0;
		for (int i = 0; i < NCH; i++) begin
			if (active[i] && !found) begin
				lead_evt = evt[i];
				found    = 1'b1;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			wire [CNT_W-1:0] first = CNT_W'(SINC_ORDER) * period
					+ CNT_W'(phase_ff[8*g+:8]) * dm_div;

			// reset pin held low idles every channel
			assign active[g] = ADC_RESET_N_IN && !ctrl_ff[CTRL_SRST_LSB+g]
					&& !ctrl_ff[CTRL_SHDN_LSB+g]; // R11
			assign evt[g]    = active[g] && !restart_ff && cnt_ff[g] == '0;
			assign latch[g]  = joint ? (lead_evt && active[g]) : evt[g]; // R13

			always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
				if (!RST_N_IN) begin
					cnt_ff[g] <= '0;
				end else if (!active[g] || restart_ff) begin
					cnt_ff[g] <= first - 1'b1; // R2 R6
				end else if (cnt_ff[g] == '0) begin
					cnt_ff[g] <= period - 1'b1; // R7
				end else begin
					cnt_ff[g] <= cnt_ff[g] - 1'b1;
				end
			end

			always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
				if (!RST_N_IN) begin
					data_ff[g] <= '0;
				end else if (restart_ff && active[g]) begin
					data_ff[g] <= '0; // R2
				end else if (latch[g]) begin
					data_ff[g] <= CH_RESULT_IN[DW*g+:DW]; // R5 R13
				end
			end

			// new data wins over a read start in the same cycle
			always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
				if (!RST_N_IN) begin
					ready_n_ff[g] <= 1'b1;
				end else if (latch[g]) begin
					ready_n_ff[g] <= 1'b0; // R17
				end else if (rd_start[g] || (restart_ff && active[g])) begin
					ready_n_ff[g] <= 1'b1;
				end
			end
		end
	endgenerate

	// conversion-done pin; chip select plays no part here
	wire             trig      = joint ? lead_evt : |evt; // R10
	wire [CNT_W-1:0] nxt_pulse = !ADC_RESET_N_IN ? '0 : trig ? half_dm :
			(pulse_ff != '0) ? pulse_ff - 1'b1 : '0; // R4
	wire             nxt_low   = ADC_RESET_N_IN && (alert || nxt_pulse != '0); // R11 R12 R24

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			pulse_ff   <= '0;
			done_n_ff  <= 1'b1;
			done_oe_ff <= 1'b0;
		end else begin
			pulse_ff   <= nxt_pulse;
			done_n_ff  <= !nxt_low;
			done_oe_ff <= nxt_low || ctrl_ff[CTRL_HIZ]; // R8
		end
	end

	assign CONV_DONE_N_OUT  = done_n_ff;
	assign CONV_DONE_OE_OUT = done_oe_ff;

	// serial read engine, mode 0,0: bits change on sck falling edge
	wire             sck_fall = sck_q_ff && !SCK_IN;
	wire             loop_md  = ctrl_ff[CTRL_LOOP];
	wire [CH_W-1:0]  start_ch = ctrl_ff[CTRL_START_LSB+:CH_W];
	wire [CH_W-1:0]  set_frst = loop_md ? '0 : start_ch;
	wire [CH_W-1:0]  set_last = loop_md ? CH_W'(NCH - 1) : start_ch;
	wire [15:0]      crc_bit  = crc_step(crc_ff, sh_ff[31]); // R19

	adr_spi_e        nxt_state;
	logic [CH_W-1:0] nxt_ch;
	logic [4:0]      nxt_bit;
	logic [31:0]     nxt_sh;
	logic [15:0]     nxt_crc;
	logic [15:0]     nxt_chk;
	logic [CH_W-1:0] ld_ch;
	logic            ld;

	always_comb begin
		nxt_state = state_ff;
		nxt_ch    = ch_ff;
		nxt_bit   = bit_ff;
		nxt_sh    = sh_ff;
		nxt_crc   = crc_ff;
		nxt_chk   = chk_ff;
		ld        = 1'b0;
		ld_ch     = ch_ff;
		if (CS_N_IN) begin
			nxt_state = SP_IDLE;
		end else begin
			unique case (state_ff)
				SP_IDLE: begin
					ld      = 1'b1;
					ld_ch   = start_ch;
					nxt_crc = CRC_INIT; // R25
				end
				SP_DATA: begin
					if (sck_fall) begin
						if (bit_ff != '0) begin
							nxt_sh  = {sh_ff[30:0], 1'b0};
							nxt_bit = bit_ff - 1'b1;
							nxt_crc = crc_bit; // R18
						end else if (ch_ff == set_last) begin
							if (ctrl_ff[CTRL_CRC_EN]) begin
								nxt_state = SP_CRC; // R22
								nxt_sh    = {crc_bit, 16'h0000}; // R20
								nxt_bit   = ctrl_ff[CTRL_CRC32] ? 5'h1F : 5'h0F; // R20
								nxt_chk   = crc_bit;
							end else begin
								ld      = 1'b1;
								ld_ch   = set_frst; // R23
								nxt_crc = CRC_INIT; // R25
							end
						end else begin
							ld      = 1'b1;
							ld_ch   = ch_ff + 1'b1;
							nxt_crc = crc_bit;
						end
					end
				end
				SP_CRC: begin
					if (sck_fall) begin
						if (bit_ff != '0) begin
							nxt_sh  = {sh_ff[30:0], 1'b0};
							nxt_bit = bit_ff - 1'b1;
						end else begin
							ld      = 1'b1;
							ld_ch   = set_frst; // R23
							nxt_crc = CRC_INIT; // R25
						end
					end
				end
			endcase
		end
		if (ld) begin
			nxt_state = SP_DATA;
			nxt_ch    = ld_ch;
			nxt_bit   = 5'(DW - 1);
			nxt_sh    = {data_ff[ld_ch], {(32-DW){1'b0}}}; // R14
		end
	end

	always_comb begin
		rd_start = '0;
		if (ld) begin
			rd_start[ld_ch] = 1'b1;
		end
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sck_q_ff <= 1'b0;
			state_ff <= SP_IDLE;
			ch_ff    <= '0;
			bit_ff   <= '0;
			sh_ff    <= '0;
			crc_ff   <= CRC_INIT;
			chk_ff   <= '0;
		end else begin
			sck_q_ff <= SCK_IN;
			state_ff <= nxt_state;
			ch_ff    <= nxt_ch;
			bit_ff   <= nxt_bit;
			sh_ff    <= nxt_sh;
			crc_ff   <= nxt_crc;
			chk_ff   <= nxt_chk;
		end
	end

	// data bits and checksum leave straight from the shift register
	assign SDO_OUT    = sh_ff[31];
	assign SDO_OE_OUT = state_ff != SP_IDLE;

endmodule : adr_core

// *** tb/adr_checker.sv ***
// adr_checker: port-level assertions on the conversion-done pin, serial port and register reads
// assumes it is bound onto adr_core; serial lines are synchronous to MCLK_IN
`timescale 1ns/1ps
module adr_checker (
	// clock and reset
	input wire logic			MCLK_IN,
	input wire logic			RST_N_IN,
	// converter side
	input wire logic			ADC_RESET_N_IN,
	input wire logic			CFG_CRC_MISMATCH_IN,
	input wire logic			CONV_DONE_N_OUT,
	input wire logic			CONV_DONE_OE_OUT,
	// serial port
	input wire logic			SCK_IN,
	input wire logic			CS_N_IN,
	input wire logic			SDO_OUT,
	input wire logic			SDO_OE_OUT,
	// axi read
	input wire logic			S_AXI_ARVALID_IN,
	input wire logic			S_AXI_ARREADY_OUT,
	input wire logic			S_AXI_RVALID_OUT,
	input wire logic [adr_pkg::DATA_W-1:0]	S_AXI_RDATA_OUT,
	input wire logic [1:0]			S_AXI_RRESP_OUT
);
	import adr_pkg::*;
	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (!RST_N_IN);

	// eight cycles covers the widest prescaler setting
	pulse_width_a: assert property (
		$fell(CONV_DONE_N_OUT) && !CFG_CRC_MISMATCH_IN
		|-> ##[1:8] (CONV_DONE_N_OUT || CFG_CRC_MISMATCH_IN))
		else $error("conversion-done pulse too long");
	reset_idle_a: assert property (
		(!ADC_RESET_N_IN ##1 !ADC_RESET_N_IN) |-> CONV_DONE_N_OUT)
		else $error("conversion-done low during converter reset");
	low_driven_a: assert property (
		!CONV_DONE_N_OUT |-> CONV_DONE_OE_OUT)
		else $error("conversion-done low without drive");
	sdo_shift_edge_a: assert property (
		$changed(SDO_OUT) && SDO_OE_OUT && $past(SDO_OE_OUT)
		|-> $past(SCK_IN, 2) && !$past(SCK_IN))
		else $error("serial data moved without a clock fall");
	sdo_abort_a: assert property (
		CS_N_IN |=> !SDO_OE_OUT)
		else $error("serial output still driven after deselect");
	read_latency_a: assert property (
		S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
		else $error("read answer late");
	read_block_a: assert property (
		S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
		else $error("read address accepted while answer pending");
	slverr_zero_a: assert property (
		S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == RESP_SLVERR |-> S_AXI_RDATA_OUT == '0)
		else $error("error read returned data");
endmodule : adr_checker

// *** tb/adr_host.sv ***
// adr_host: serial host model, mode 0,0, clocks whole words out of the device
// assumes its clock is the system clock; serial clock rests low outside frames
`timescale 1ns/1ps
module adr_host (
	// system clock
	input  wire logic	mclk_in,
	// serial lines
	input  wire logic	sdo_in,
	output logic		sck_out,
	output logic		cs_n_out
);
	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
	end

	// half sets the pace; n counts bits, channel words plus any checksum fields
	task automatic xfer(input int n, input int half, output logic [255:0] bits);
		bits = '0;
		@(posedge mclk_in);
		cs_n_out <= 1'b0;
		repeat (half) @(posedge mclk_in);
		for (int i = 0; i < n; i++) begin
			@(negedge mclk_in);
			bits = {bits[254:0], sdo_in};
			@(posedge mclk_in);
			sck_out <= 1'b1;
			repeat (half) @(posedge mclk_in);
			sck_out <= 1'b0;
			repeat (half) @(posedge mclk_in);
		end
		cs_n_out <= 1'b1;
	endtask : xfer
endmodule : adr_host

// *** tb/adr_core_tb_top.sv ***
// adr_core_tb_top: self-checking bench, register bus master plus serial host model
// assumes adr_pkg, adr_core, adr_host and adr_checker are compiled first
`timescale 1ns/1ps
module adr_core_tb_top;
	import adr_pkg::*;
	localparam logic [23:0] C0 = 24'h123456, C1 = 24'hABCDEF, C2 = 24'h0F1E2D, C3 = 24'h9A8B7C;
	localparam int PER = DIVCLK_MIN * BASE_RATIO;
	logic			mclk, rst_n, adc_rst_n, mism, awvalid, wvalid, bready, arvalid, rready;
	logic [ADDR_W-1:0]	awaddr, araddr;
	logic [DATA_W-1:0]	wdata;
	wire logic		awready, wready, bvalid, arready, rvalid, sdo, sdo_oe, done_n, done_oe, sck, cs_n;
	wire logic [1:0]	bresp, rresp;
	wire logic [DATA_W-1:0]	rdata;
	int			bad_count = 0, n_compared = 0, cyc = 0;

	adr_core DUT (.MCLK_IN(mclk), .RST_N_IN(rst_n),
		.S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_AWADDR_IN(awaddr),
		.S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready), .S_AXI_WDATA_IN(wdata),
		.S_AXI_WSTRB_IN(4'hF), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
		.S_AXI_BRESP_OUT(bresp), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
		.S_AXI_ARADDR_IN(araddr), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
		.S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .ADC_RESET_N_IN(adc_rst_n),
		.CH_RESULT_IN({C3, C2, C1, C0}), .CFG_CRC_MISMATCH_IN(mism), .SCK_IN(sck),
		.CS_N_IN(cs_n), .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .CONV_DONE_N_OUT(done_n),
		.CONV_DONE_OE_OUT(done_oe));
	adr_host host (.mclk_in(mclk), .sdo_in(sdo), .sck_out(sck), .cs_n_out(cs_n));

	initial mclk = 1'b0;
	always #4 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;

	task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [1:0] resp);
		bit aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge mclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready) aw_done = 1'b1;
			if (wready) w_done = 1'b1;
			if (aw_done) awvalid <= 1'b0;
			if (w_done) wvalid <= 1'b0;
		end while (!(aw_done && w_done));
		do @(posedge mclk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
		output logic [1:0] resp);
		@(posedge mclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(posedge mclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge mclk); while (rvalid !== 1'b1);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	// returns the cycle count at the negedge that first sees the pin low
	task automatic wait_fall(output int c);
		logic prev;
		prev = 1'b0;
		forever begin
			@(negedge mclk);
			if (prev === 1'b1 && done_n === 1'b0) break;
			prev = done_n;
		end
		c = cyc;
	endtask : wait_fall

	function automatic logic [15:0] crc16(input logic [255:0] m, input int n);
		logic [15:0] c;
		c = CRC_INIT;
		for (int i = n - 1; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((m[i] ^ c[15]) ? CRC_POLY : 16'h0000);
		return c;
	endfunction : crc16

	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(OFS_CTRL, d, r);
		check("ctrl reset", d, CTRL_RST);
		axi_rd(OFS_CONV, d, r);
		check("conv reset", d, CONV_RST);
		axi_rd(OFS_PHASE, d, r);
		check("phase reset", d, PHASE_RST);
		axi_rd(8'h40, d, r);
		check("unmapped read resp", r, RESP_SLVERR);
		axi_wr(OFS_DATA0, 32'hFFFF_FFFF, r);
		check("data write resp", r, RESP_SLVERR);
		$display("test regs done");
	endtask : t_regs

	task automatic t_restart;
		logic [31:0] d;
		logic [1:0] r;
		int c0, c1, c2, c3;
		axi_wr(OFS_CONV, 32'h0000_0000, r);
		wait_fall(c0);
		axi_rd(OFS_DATA0, d, r);
		check("data before restart", d[23:0], C0);
		axi_wr(OFS_PHASE, 32'h0000_0000, r);
		c1 = cyc;
		axi_rd(OFS_DATA0, d, r);
		check("data after rewrite", d[23:0], 24'h0);
		wait_fall(c0);
		check("first pulse window", c0 - c1 >= 3 * PER - 4 && c0 - c1 <= 3 * PER + 8, 1);
		axi_wr(OFS_PHASE, 32'h0000_0005, r);
		c2 = cyc;
		wait_fall(c3);
		check("phase delay", (c3 - c2) - (c0 - c1), 5 * DIVCLK_MIN);
		$display("test restart done");
	endtask : t_restart

	task automatic t_timing;
		logic [255:0] got;
		logic [1:0] r;
		int c0, c1, w;
		axi_wr(OFS_CTRL, 32'h0000_1300, r);
		wait_fall(c0);
		w = 1;
		@(negedge mclk);
		while (done_n === 1'b0 && w < 20) begin
			w++;
			@(negedge mclk);
		end
		check("pulse width", w, DIVCLK_MIN / 2);
		wait_fall(c0);
		wait_fall(c1);
		check("period", c1 - c0, PER);
		fork
			host.xfer(48, 10, got);
			begin
				repeat (20) @(posedge mclk);
				wait_fall(c0);
				wait_fall(c1);
			end
		join
		check("period while selected", c1 - c0, PER);
		check("two channel read", got[47:0], {C0, C1});
		$display("test timing done");
	endtask : t_timing

	task automatic t_stream;
		logic [255:0] got;
		logic [95:0] seq;
		logic [15:0] crc, crc2;
		logic [31:0] d;
		logic [1:0] r;
		int c;
		seq = {C0, C1, C2, C3};
		crc = crc16(seq, 96);
		crc2 = crc16(C2, 24);
		axi_wr(OFS_CTRL, 32'h0000_1700, r);
		wait_fall(c);
		axi_rd(OFS_STAT, d, r);
		check("ready flags", d[3:0], 4'h0);
		host.xfer(224, 4, got);
		check("first sequence", got[223:112], {seq, crc});
		check("second sequence", got[111:0], {seq, crc});
		check("crc residue", crc16(got[111:0], 112), 16'h0000);
		axi_wr(OFS_CTRL, 32'h0000_1F00, r);
		host.xfer(128, 6, got);
		check("wide crc field", got[127:0], {seq, crc, 16'h0000});
		axi_wr(OFS_CTRL, 32'h0000_4700, r);
		host.xfer(80, 4, got);
		check("static set", got[79:0], {C2, crc2, C2, crc2});
		repeat (2) @(negedge mclk);
		check("serial released", sdo_oe, 1'b0);
		axi_rd(OFS_CHK, d, r);
		check("checksum register", d[15:0], crc2);
		$display("test stream done");
	endtask : t_stream

	task automatic t_alert;
		logic [1:0] r;
		int c;
		axi_wr(OFS_CTRL, 32'h0000_8200, r);
		wait_fall(c);
		repeat (3) @(negedge mclk);
		check("idle floats", done_oe, 1'b0);
		@(posedge mclk);
		mism <= 1'b1;
		repeat (150) @(negedge mclk);
		check("alert held low", {done_oe, done_n}, 2'b10);
		@(posedge mclk);
		mism <= 1'b0;
		axi_wr(OFS_CTRL, 32'h0000_1300, r);
		wait_fall(c);
		repeat (3) @(negedge mclk);
		check("idle driven high", {done_oe, done_n}, 2'b11);
		$display("test alert done");
	endtask : t_alert

	task automatic t_adc_reset;
		logic [1:0] r;
		int c;
		axi_wr(OFS_CTRL, 32'h0000_9300, r);
		@(posedge mclk);
		adc_rst_n <= 1'b0;
		@(posedge mclk);
		mism <= 1'b1;
		repeat (2) @(negedge mclk);
		c = 0;
		repeat (300) begin
			@(negedge mclk);
			if (done_n !== 1'b1) c++;
		end
		check("low cycles in converter reset", c, 0);
		@(posedge mclk);
		adc_rst_n <= 1'b1;
		mism <= 1'b0;
		wait_fall(c);
		$display("test converter reset done");
	endtask : t_adc_reset

	task automatic summarize;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	initial begin
		rst_n = 1'b0;
		adc_rst_n = 1'b1;
		mism = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		t_regs();
		t_restart();
		t_timing();
		t_stream();
		t_alert();
		t_adc_reset();
		summarize();
	end

	// all tests together take well under ten thousand cycles
	initial begin
		repeat (40000) @(posedge mclk);
		bad_count++;
		summarize();
	end
endmodule : adr_core_tb_top

bind adr_core adr_checker u_chk (.MCLK_IN, .RST_N_IN, .ADC_RESET_N_IN, .CFG_CRC_MISMATCH_IN,
	.CONV_DONE_N_OUT, .CONV_DONE_OE_OUT, .SCK_IN, .CS_N_IN, .SDO_OUT, .SDO_OE_OUT,
	.S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT, .S_AXI_RVALID_OUT, .S_AXI_RDATA_OUT,
	.S_AXI_RRESP_OUT);
